/* inc/uart_lin_ext_pkg.sv */
package uart_lin_ext_pkg;
    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_STATUS_TWO   = 4'h0;
    localparam logic [3:0] ADDR_CONTROL_THREE = 4'h4;
    localparam logic [3:0] ADDR_MODE          = 4'h8;
    localparam int         ADDR_W             = 4;

    // ------------------------------------------------------------
    // status_two_reg fields
    // ------------------------------------------------------------
    localparam int S2_LIN_BREAK   = 7;
    localparam int S2_RX_EDGE     = 6;
    localparam int S2_RX_INVERT   = 4;
    localparam int S2_WAKE_IDLE   = 3;
    localparam int S2_LONG_BREAK  = 2;
    localparam int S2_LIN_DETECT  = 1;
    localparam int S2_RX_ACTIVE   = 0;

    // ------------------------------------------------------------
    // control_three_reg fields
    // ------------------------------------------------------------
    localparam int C3_RX_NINTH    = 7;
    localparam int C3_TX_NINTH    = 6;
    localparam int C3_DIRECTION   = 5;
    localparam int C3_TX_INVERT   = 4;
    localparam int C3_OVERRUN_IE  = 3;
    localparam int C3_NOISE_IE    = 2;
    localparam int C3_FRAMING_IE  = 1;
    localparam int C3_PARITY_IE   = 0;

    // ------------------------------------------------------------
    // mode register fields
    // ------------------------------------------------------------
    localparam int MODE_NINE_BIT  = 0;
    localparam int MODE_LOOPBACK  = 1;
    localparam int MODE_RX_SOURCE = 2;
    localparam int MODE_STANDBY   = 3;

    localparam logic [7:0] REG_RESET = 8'h00;

    // ------------------------------------------------------------
    // bit-time lengths
    // ------------------------------------------------------------
    localparam logic [3:0] BREAK_TX_SHORT = 4'hA;
    localparam logic [3:0] BREAK_TX_LONG  = 4'hD;
    localparam logic [3:0] BREAK_RX_BASE  = 4'hA;
    localparam logic [3:0] ONE_BIT        = 4'h1;

    // ------------------------------------------------------------
    // axi responses
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* rtl/uart_lin_status_control_ext.sv */
`timescale 1ns/1ps
module uart_lin_status_control_ext (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address and data
    input  wire logic [3:0]  awaddr,
    input  wire logic [2:0]  awprot,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    // axi4-lite write response
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // axi4-lite read
    input  wire logic [3:0]  araddr,
    input  wire logic [2:0]  arprot,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // serial core events
    input  wire logic        bit_tick,
    input  wire logic        rx_start_seen,
    input  wire logic        rx_idle_seen,
    input  wire logic        rx_char_done,
    input  wire logic        rx_frame_bad,
    input  wire logic        rx_ninth_in,
    input  wire logic        tx_data_write,
    input  wire logic [7:0]  tx_data_in,
    input  wire logic        tx_break_req,
    input  wire logic        tx_serial_raw,
    // main status flag levels
    input  wire logic        overrun_flag,
    input  wire logic        noise_flag,
    input  wire logic        framing_err_flag,
    input  wire logic        parity_err_flag,
    // serial pins
    input  wire logic        rx_pin,
    input  wire logic        tx_pin_in,
    output logic             tx_pin_out,
    output logic             tx_pin_oe,
    // toward the serial core
    output logic             rx_serial,
    output logic             tx_line_in,
    output logic             rx_full_set,
    output logic             framing_set,
    output logic             idle_set,
    output logic             break_seen,
    output logic             tx_shift_load,
    output logic [8:0]       tx_shift_word,
    output logic             nine_bit_mode,
    output logic             err_irq
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] status_two_reg;
    logic [7:0] control_three_reg;
    logic [7:0] mode_reg;
    logic       rx_prev;
    logic [3:0] low_count;
    logic [3:0] brk_left;
    logic       wr_go;
    logic       rd_go;
    logic [3:0] wr_addr;
    logic [7:0] wr_byte;
    logic       wr_lane;

    logic       lin_detect_enable;
    logic       rx_polarity_invert;
    logic       tx_polarity_invert;
    logic       long_break_select;
    logic       wake_idle_report;
    logic       single_wire_direction;
    logic       loopback_select;
    logic       rx_source_select;
    logic       rx_wakeup_standby;
    logic       single_wire;
    logic       next_rx;
    logic       edge_event;
    logic       break_event;
    logic [3:0] rx_threshold;
    logic [3:0] tx_break_len;

    assign lin_detect_enable     = status_two_reg[uart_lin_ext_pkg::S2_LIN_DETECT];
    assign rx_polarity_invert    = status_two_reg[uart_lin_ext_pkg::S2_RX_INVERT];
    assign wake_idle_report      = status_two_reg[uart_lin_ext_pkg::S2_WAKE_IDLE];
    assign long_break_select     = status_two_reg[uart_lin_ext_pkg::S2_LONG_BREAK];
    assign tx_polarity_invert    = control_three_reg[uart_lin_ext_pkg::C3_TX_INVERT];
    assign single_wire_direction = control_three_reg[uart_lin_ext_pkg::C3_DIRECTION];
    assign loopback_select       = mode_reg[uart_lin_ext_pkg::MODE_LOOPBACK];
    assign rx_source_select      = mode_reg[uart_lin_ext_pkg::MODE_RX_SOURCE];
    assign rx_wakeup_standby     = mode_reg[uart_lin_ext_pkg::MODE_STANDBY];
    assign single_wire           = loopback_select & rx_source_select;

    // ------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------
    // both halves of a write are taken together, one cycle after both valid
    assign wr_go   = awvalid & wvalid & awready & wready;
    assign rd_go   = arvalid & arready;
    assign wr_addr = awaddr;
    assign wr_byte = wdata[7:0];
    assign wr_lane = wstrb[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b0;
            wready  <= 1'b0;
        end else begin
            awready <= awvalid & wvalid & ~awready & ~bvalid;
            wready  <= awvalid & wvalid & ~wready & ~bvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= uart_lin_ext_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid <= 1'b1;
            if (wr_addr == uart_lin_ext_pkg::ADDR_STATUS_TWO
                || wr_addr == uart_lin_ext_pkg::ADDR_CONTROL_THREE
                || wr_addr == uart_lin_ext_pkg::ADDR_MODE) begin
                bresp <= uart_lin_ext_pkg::RESP_OKAY;
            end else begin
                bresp <= uart_lin_ext_pkg::RESP_SLVERR;
            end
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
        end else begin
            arready <= arvalid & ~arready & ~rvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= uart_lin_ext_pkg::RESP_OKAY;
        end else if (rd_go) begin
            rvalid <= 1'b1;
            rresp  <= uart_lin_ext_pkg::RESP_OKAY;
            case (araddr)
                uart_lin_ext_pkg::ADDR_STATUS_TWO:    rdata <= {24'h00_0000, status_two_reg};
                uart_lin_ext_pkg::ADDR_CONTROL_THREE: rdata <= {24'h00_0000, control_three_reg};
                uart_lin_ext_pkg::ADDR_MODE:          rdata <= {24'h00_0000, mode_reg};
                default: begin
                    rdata <= 32'h0000_0000;
                    rresp <= uart_lin_ext_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // receive line conditioning
    // ------------------------------------------------------------
    // single-wire mode takes the receive stream from the tx pin
    // input polarity flip
    assign next_rx = (single_wire ? tx_pin_in : rx_pin) ^ rx_polarity_invert;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_serial <= 1'b1;
            rx_prev   <= 1'b1;
        end else begin
            rx_serial <= next_rx;
            rx_prev   <= rx_serial;
        end
    end

    // falling edge of the conditioned stream
    assign edge_event = rx_prev & ~rx_serial;

    // ------------------------------------------------------------
    // break detection
    // ------------------------------------------------------------
    // threshold from frame length and lin enable
    // nine-bit frames add one bit time
    assign rx_threshold = uart_lin_ext_pkg::BREAK_RX_BASE
                          + (nine_bit_mode ? uart_lin_ext_pkg::ONE_BIT : 4'h0)
                          + (lin_detect_enable ? uart_lin_ext_pkg::ONE_BIT : 4'h0);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            low_count <= 4'h0;
        end else if (rx_serial) begin
            low_count <= 4'h0;
        end else if (bit_tick && low_count != rx_threshold) begin
            low_count <= low_count + uart_lin_ext_pkg::ONE_BIT;
        end
    end

    assign break_event = bit_tick & ~rx_serial
                         & (low_count + uart_lin_ext_pkg::ONE_BIT == rx_threshold);

    // ------------------------------------------------------------
    // status_two_reg
    // ------------------------------------------------------------
    // flag set wins over a write-one clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_two_reg <= uart_lin_ext_pkg::REG_RESET;
        end else begin
            if (wr_go && wr_lane && wr_addr == uart_lin_ext_pkg::ADDR_STATUS_TWO) begin
                status_two_reg[uart_lin_ext_pkg::S2_RX_INVERT]  <=
                    wr_byte[uart_lin_ext_pkg::S2_RX_INVERT];
                status_two_reg[uart_lin_ext_pkg::S2_WAKE_IDLE]  <=
                    wr_byte[uart_lin_ext_pkg::S2_WAKE_IDLE];
                status_two_reg[uart_lin_ext_pkg::S2_LONG_BREAK] <=
                    wr_byte[uart_lin_ext_pkg::S2_LONG_BREAK];
                status_two_reg[uart_lin_ext_pkg::S2_LIN_DETECT] <=
                    wr_byte[uart_lin_ext_pkg::S2_LIN_DETECT];
            end
            // lin break flag, write one clears
            if (break_event && lin_detect_enable) begin
                status_two_reg[uart_lin_ext_pkg::S2_LIN_BREAK] <= 1'b1;
            end else if (wr_go && wr_lane && wr_addr == uart_lin_ext_pkg::ADDR_STATUS_TWO
                         && wr_byte[uart_lin_ext_pkg::S2_LIN_BREAK]) begin
                status_two_reg[uart_lin_ext_pkg::S2_LIN_BREAK] <= 1'b0;
            end
            if (edge_event) begin
                status_two_reg[uart_lin_ext_pkg::S2_RX_EDGE] <= 1'b1;
            end else if (wr_go && wr_lane && wr_addr == uart_lin_ext_pkg::ADDR_STATUS_TWO
                         && wr_byte[uart_lin_ext_pkg::S2_RX_EDGE]) begin
                status_two_reg[uart_lin_ext_pkg::S2_RX_EDGE] <= 1'b0;
            end
            // receiver active follows start and idle
            if (rx_start_seen) begin
                status_two_reg[uart_lin_ext_pkg::S2_RX_ACTIVE] <= 1'b1;
            end else if (rx_idle_seen) begin
                status_two_reg[uart_lin_ext_pkg::S2_RX_ACTIVE] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // control_three_reg and mode register
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            control_three_reg <= uart_lin_ext_pkg::REG_RESET;
        end else begin
            if (wr_go && wr_lane && wr_addr == uart_lin_ext_pkg::ADDR_CONTROL_THREE) begin
                // ninth receive bit is read only
                control_three_reg[6:0] <= wr_byte[6:0];
            end
            // latch received ninth bit with its character
            if (rx_char_done && !lin_detect_enable) begin
                control_three_reg[uart_lin_ext_pkg::C3_RX_NINTH] <=
                    nine_bit_mode & rx_ninth_in;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_reg <= uart_lin_ext_pkg::REG_RESET;
        end else if (wr_go && wr_lane && wr_addr == uart_lin_ext_pkg::ADDR_MODE) begin
            mode_reg[3:0] <= wr_byte[3:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nine_bit_mode <= 1'b0;
        end else begin
            nine_bit_mode <= (wr_go && wr_lane && wr_addr == uart_lin_ext_pkg::ADDR_MODE)
                             ? wr_byte[uart_lin_ext_pkg::MODE_NINE_BIT]
                             : mode_reg[uart_lin_ext_pkg::MODE_NINE_BIT];
        end
    end

    // ------------------------------------------------------------
    // receive event gating
    // ------------------------------------------------------------
    // framing uses only the received stop bit, never break length
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_full_set <= 1'b0;
            framing_set <= 1'b0;
            idle_set    <= 1'b0;
            break_seen  <= 1'b0;
        end else begin
            // lin detection blocks full and framing
            rx_full_set <= rx_char_done & ~lin_detect_enable;
            framing_set <= rx_char_done & rx_frame_bad & ~lin_detect_enable;
            // idle in standby only when reported
            idle_set    <= rx_idle_seen & (~rx_wakeup_standby | wake_idle_report);
            break_seen  <= break_event;
        end
    end

    // ------------------------------------------------------------
    // transmit side
    // ------------------------------------------------------------
    // break length from long select and frame size
    assign tx_break_len = (long_break_select ? uart_lin_ext_pkg::BREAK_TX_LONG
                                             : uart_lin_ext_pkg::BREAK_TX_SHORT)
                          + (nine_bit_mode ? uart_lin_ext_pkg::ONE_BIT : 4'h0);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            brk_left <= 4'h0;
        end else if (tx_break_req && brk_left == 4'h0) begin
            brk_left <= tx_break_len;
        end else if (bit_tick && brk_left != 4'h0) begin
            brk_left <= brk_left - uart_lin_ext_pkg::ONE_BIT;
        end
    end

    // nine bits move on a data write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_shift_load <= 1'b0;
            tx_shift_word <= 9'h000;
        end else begin
            tx_shift_load <= tx_data_write;
            if (tx_data_write) begin
                tx_shift_word <= {nine_bit_mode
                                  & control_three_reg[uart_lin_ext_pkg::C3_TX_NINTH],
                                  tx_data_in};
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_pin_out <= 1'b1;
            tx_pin_oe  <= 1'b1;
            tx_line_in <= 1'b1;
        end else begin
            tx_pin_out <= ((brk_left == 4'h0) & tx_serial_raw) ^ tx_polarity_invert;
            tx_pin_oe  <= ~single_wire | single_wire_direction;
            tx_line_in <= tx_pin_in;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            err_irq <= 1'b0;
        end else begin
            err_irq <= (overrun_flag & control_three_reg[uart_lin_ext_pkg::C3_OVERRUN_IE])
                     | (noise_flag & control_three_reg[uart_lin_ext_pkg::C3_NOISE_IE])
                     | (framing_err_flag & control_three_reg[uart_lin_ext_pkg::C3_FRAMING_IE])
                     | (parity_err_flag & control_three_reg[uart_lin_ext_pkg::C3_PARITY_IE]);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_lin_flag_set: assert property (
        break_event && lin_detect_enable |=> status_two_reg[uart_lin_ext_pkg::S2_LIN_BREAK])
        else $error("lin break flag not set");
    chk_edge_flag_set: assert property (
        edge_event |=> status_two_reg[uart_lin_ext_pkg::S2_RX_EDGE])
        else $error("edge flag not set");
    chk_rx_invert: assert property (
        $stable(rx_polarity_invert) && !single_wire
        |=> rx_serial == ($past(rx_pin) ^ $past(rx_polarity_invert)))
        else $error("receive polarity wrong");
    chk_idle_gate: assert property (
        rx_wakeup_standby && !wake_idle_report |=> !idle_set)
        else $error("idle set in standby");
    chk_lin_blocks: assert property (
        lin_detect_enable |=> !rx_full_set && !framing_set)
        else $error("full or framing set with lin enabled");
    chk_active_flag: assert property (
        rx_start_seen |=> status_two_reg[uart_lin_ext_pkg::S2_RX_ACTIVE])
        else $error("receiver active not set");
    chk_break_hold: assert property (
        tx_break_req && brk_left == 4'h0 && !tx_polarity_invert
        ##1 !tx_polarity_invert |=> !tx_pin_out)
        else $error("break not driven low");
    chk_pin_dir: assert property (
        single_wire && !single_wire_direction |=> !tx_pin_oe)
        else $error("tx pin driven as input");
    chk_irq_merge: assert property (
        !overrun_flag && !noise_flag && !framing_err_flag && !parity_err_flag |=> !err_irq)
        else $error("error request without flag");
    chk_irq_overrun: assert property (
        overrun_flag && control_three_reg[uart_lin_ext_pkg::C3_OVERRUN_IE] |=> err_irq)
        else $error("overrun request missing");

    cov_lin_break: cover property (break_event && lin_detect_enable);
    cov_tx_break: cover property (tx_break_req ##1 brk_left != 4'h0);
    cov_write_read: cover property (wr_go ##[1:4] rd_go);
endmodule

/* testbench/remote_node.sv */
`timescale 1ns/1ps
module remote_node (
    // clock and bit timing
    input  wire logic       aclk,
    input  wire logic       bit_tick,
    // commands from the bench
    input  wire logic       low_go,
    input  wire logic [4:0] low_bits,
    input  wire logic       line_invert,
    // serial line toward the device
    output logic            rx_pin
);
    logic [4:0] left = 5'h0;
    // holds the line active for whole bit times, counted on the shared tick
    always_ff @(posedge aclk) begin
        if (low_go) begin
            left <= low_bits;
        end else if (bit_tick && left != 5'h0) begin
            left <= left - 5'h1;
        end
    end
    assign rx_pin = (left == 5'h0) ^ line_invert;
endmodule

/* testbench/uart_lin_status_control_ext_bench.sv */
`timescale 1ns/1ps
module uart_lin_status_control_ext_bench;
    logic aclk = 1'b0;
    logic aresetn, awvalid, wvalid, bready, arvalid, rready, low_go, line_invert;
    logic rx_start_seen, rx_idle_seen, rx_char_done, rx_frame_bad, rx_ninth_in;
    logic tx_data_write, tx_break_req, tx_serial_raw, overrun_flag, noise_flag;
    logic framing_err_flag, parity_err_flag, rx_pin, tx_pin_in, bit_tick;
    logic awready, wready, bvalid, arready, rvalid, tx_pin_out, tx_pin_oe, rx_serial;
    logic tx_line_in, rx_full_set, framing_set, idle_set, break_seen, tx_shift_load;
    logic nine_bit_mode, err_irq;
    logic [1:0]  bresp, rresp, rr, div;
    logic [2:0]  awprot, arprot;
    logic [3:0]  awaddr, araddr, wstrb;
    logic [4:0]  low_bits;
    logic [7:0]  tx_data_in;
    logic [8:0]  tx_shift_word;
    logic [31:0] wdata, rdata, rq;
    int          miscompares = 0, compares = 0, cyc = 0, n, brk_hits = 0;

    uart_lin_status_control_ext i_dut (.*);
    remote_node i_far (.aclk, .bit_tick, .low_go, .low_bits, .line_invert, .rx_pin);

    // undriven pin floats high, as with a pull-up
    assign tx_pin_in = tx_pin_oe ? tx_pin_out : 1'b1;
    // one bit time is four clocks, short enough to keep breaks cheap
    assign bit_tick = (div == 2'h3);
    initial forever #50 aclk = ~aclk;
    always_ff @(posedge aclk) div <= aresetn ? div + 2'h1 : 2'h0;
    always @(posedge aclk) if (break_seen) brk_hits++;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            miscompares++;
            close_out;
        end
    end

    // ------------------------------------------------------------
    // bus and check tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= {24'h00_0000, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do @(posedge aclk); while (!(awready && wready));
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
        do @(posedge aclk); while (!bvalid);
        rr = bresp;
        bready  <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rq = rdata;
        rr = rresp;
        rready  <= 1'b0;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [3:0] a, input logic [31:0] e);
        rd(a);
        cmp(rq, e);
    endtask
    // one-cycle core events; the registered pulses stand one edge later
    task automatic ev(input logic [3:0] e, input logic [3:0] x);
        @(posedge aclk);
        {tx_data_write, rx_char_done, rx_idle_seen, rx_start_seen} <= e;
        @(posedge aclk);
        {tx_data_write, rx_char_done, rx_idle_seen, rx_start_seen} <= 4'h0;
        @(posedge aclk);
        cmp({28'h0, rx_full_set, framing_set, idle_set, tx_shift_load}, {28'h0, x});
    endtask
    // starts just after a tick so the device sees every low bit time
    task automatic send_low(input logic [4:0] b);
        do @(posedge aclk); while (!bit_tick);
        low_bits <= b;
        low_go   <= 1'b1;
        @(posedge aclk);
        low_go   <= 1'b0;
        repeat (4 * b + 8) @(posedge aclk);
    endtask
    task automatic close_out;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, low_go, line_invert} <= '0;
        {rx_start_seen, rx_idle_seen, rx_char_done, rx_frame_bad, rx_ninth_in} <= '0;
        {tx_data_write, tx_break_req, overrun_flag, noise_flag} <= '0;
        {framing_err_flag, parity_err_flag, awprot, arprot, awaddr, araddr} <= '0;
        {low_bits, tx_data_in, wdata} <= '0;
        wstrb <= 4'hF;
        tx_serial_raw <= 1'b1;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        wr(4'hC, 8'hFF);
        cmp({30'h0, rr}, {30'h0, uart_lin_ext_pkg::RESP_SLVERR});
        rdc(uart_lin_ext_pkg::ADDR_STATUS_TWO, 32'h0000_0000);
        rdc(uart_lin_ext_pkg::ADDR_CONTROL_THREE, 32'h0000_0000);
        rd(4'hC);
        cmp({30'h0, rr}, {30'h0, uart_lin_ext_pkg::RESP_SLVERR});
        $display("test reset done");
        wr(uart_lin_ext_pkg::ADDR_STATUS_TWO, 8'h02);
        send_low(5'd10);
        rdc(uart_lin_ext_pkg::ADDR_STATUS_TWO, 32'h0000_0042);
        wr(uart_lin_ext_pkg::ADDR_STATUS_TWO, 8'hC2);
        rdc(uart_lin_ext_pkg::ADDR_STATUS_TWO, 32'h0000_0002);
        send_low(5'd11);
        rdc(uart_lin_ext_pkg::ADDR_STATUS_TWO, 32'h0000_00C2);
        line_invert <= 1'b1;
        wr(uart_lin_ext_pkg::ADDR_STATUS_TWO, 8'hD2);
        @(posedge aclk);
        cmp({31'h0, rx_serial}, 32'h0000_0001);
        send_low(5'd11);
        rdc(uart_lin_ext_pkg::ADDR_STATUS_TWO, 32'h0000_00D2);
        cmp(brk_hits, 32'h0000_0002);
        $display("test break detect done");
        line_invert <= 1'b0;
        wr(uart_lin_ext_pkg::ADDR_STATUS_TWO, 8'h04);
        // request right after a tick so every bit time is whole
        do @(posedge aclk); while (!bit_tick);
        tx_break_req <= 1'b1;
        @(posedge aclk);
        tx_break_req <= 1'b0;
        n = 0;
        repeat (80) begin
            @(posedge aclk);
            if (bit_tick && tx_pin_out === 1'b0) n++;
        end
        cmp(n, 32'h0000_000D);
        cmp({31'h0, tx_pin_oe}, 32'h0000_0001);
        $display("test break send done");
        wr(uart_lin_ext_pkg::ADDR_CONTROL_THREE, 8'h08);
        overrun_flag <= 1'b1;
        repeat (3) @(posedge aclk);
        cmp({31'h0, err_irq}, 32'h0000_0001);
        wr(uart_lin_ext_pkg::ADDR_CONTROL_THREE, 8'h00);
        repeat (3) @(posedge aclk);
        cmp({31'h0, err_irq}, 32'h0000_0000);
        overrun_flag <= 1'b0;
        $display("test interrupt done");
        wr(uart_lin_ext_pkg::ADDR_MODE, 8'h01);
        wr(uart_lin_ext_pkg::ADDR_CONTROL_THREE, 8'h40);
        {tx_data_in, rx_frame_bad, rx_ninth_in} <= {8'hA5, 2'h3};
        ev(4'hC, 4'hD);
        cmp({23'h0, tx_shift_word}, 32'h0000_01A5);
        rdc(uart_lin_ext_pkg::ADDR_CONTROL_THREE, 32'h0000_00C0);
        $display("test ninth bit done");
        wr(uart_lin_ext_pkg::ADDR_STATUS_TWO, 8'hC2);
        ev(4'h4, 4'h0);
        ev(4'h1, 4'h0);
        rdc(uart_lin_ext_pkg::ADDR_STATUS_TWO, 32'h0000_0003);
        ev(4'h2, 4'h2);
        rdc(uart_lin_ext_pkg::ADDR_STATUS_TWO, 32'h0000_0002);
        wr(uart_lin_ext_pkg::ADDR_MODE, 8'h0F);
        ev(4'h2, 4'h0);
        wr(uart_lin_ext_pkg::ADDR_STATUS_TWO, 8'h0A);
        ev(4'h2, 4'h2);
        cmp({31'h0, tx_pin_oe}, 32'h0000_0000);
        wr(uart_lin_ext_pkg::ADDR_CONTROL_THREE, 8'h10);
        @(posedge aclk);
        cmp({30'h0, tx_line_in, tx_pin_out}, 32'h0000_0002);
        $display("test receive events done");
        close_out;
    end
endmodule
